/* inc/bwpb_pkg.sv */
// package for the byte-to-word port bridge: constants and carrier types
// assumes a 10 MHz system clock shared with the processor bus timing
package bwpb_pkg;
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          CS_HOLD_CYCLES = 4;
  localparam logic [2:0]  CS_CNT_INIT    = 3'h4;
  // chip select count at which a read's answer has crossed the data synchroniser
  localparam logic [2:0]  RD_CAP_CNT     = 3'h2;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [15:0] MAP_BASE_DEF   = 16'h8000;
  localparam logic [15:0] MAP_MASK_DEF   = 16'hF800;

  // synchronised processor-side controls, all active low except the address
  typedef struct packed {
    logic        rd_n;
    logic        wr_n;
    logic        load_n;
    logic        regsel_n;
    logic [15:0] addr;
  } bwpb_cpu_ctl_t;

  // terminal-side control pins
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic rd_wr_n;
    logic ctrl_n;
    logic dir_n;
  } bwpb_term_ctl_t;
endpackage : bwpb_pkg

/* core/bwpb_sync.sv */
// two-flop synchroniser for a bundle of pin inputs
// assumes inputs are asynchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module bwpb_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  // reset to all ones: every strobe in the bundle is active low, so no false edge
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta   <= '1;
      sync_o <= '1;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule : bwpb_sync
`default_nettype wire

/* core/bwpb_bridge.sv */
// byte-to-word bridge between an 8-bit processor bus and a 16-bit terminal port
// assumes the processor strobes last several clocks; all pins are synchronised first
`timescale 1ns/1ps
`default_nettype none
// Contract
// - word read latches terminal low byte; high byte passes to processor same cycle.
// - read latch captures terminal data on the falling read strobe edge; the code captures later, at chip select count RD_CAP_CNT.
// - read latch drives the processor bus only while read low and byte select low.
// - terminal output enable stays off during the low-byte read cycle.
// - terminal output enable is read strobe OR address match, both active low; the code also ORs in the low-byte read.
// - word write takes two cycles: low byte latched, then both bytes sent.
// - latch-drive signal enables the three-state write latch outputs.
// - byte select bit zero picks low byte, one picks high byte.
// - terminal read/write-not combines latch-drive and write strobe.
// - direction is zero on writes and one on reads.
// - high-byte transceiver floats during the low-byte read cycle.
// - register select chooses terminal RAM or registers.
// - chip select starts on decode plus falling strobe, held four clock cycles.
// - write latch loads when byte select low, write low, latch-drive high.
module bwpb_bridge
  import bwpb_pkg::*;
#(
  parameter logic [15:0] MAP_BASE = MAP_BASE_DEF,
  parameter logic [15:0] MAP_MASK = MAP_MASK_DEF
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // processor bus
  input  wire logic        cpu_rd_n_i,
  input  wire logic        cpu_wr_n_i,
  input  wire logic        cpu_load_n_i,
  input  wire logic        cpu_regsel_n_i,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic [7:0]  cpu_data_i,
  output logic      [7:0]  cpu_data_o,
  output logic             cpu_data_oe_o,
  // terminal port
  input  wire logic [15:0] term_data_i,
  output logic      [15:0] term_data_o,
  output logic             term_lo_oe_o,
  output logic             term_hi_oe_o,
  output logic             term_cs_n_o,
  output logic             term_oe_n_o,
  output logic             term_rd_wr_n_o,
  output logic             term_ctrl_n_o,
  output logic             term_dir_n_o
);
  localparam int CTL_W = $bits(bwpb_cpu_ctl_t);

  bwpb_cpu_ctl_t cpu_raw;
  bwpb_cpu_ctl_t cpu;
  logic [CTL_W-1:0] cpu_sync;
  logic [7:0]  data_lo_s1;
  logic [7:0]  data_lo_s2;
  logic [15:0] term_s1;
  logic [15:0] term_s2;
  logic        rd_prev;
  logic        wr_prev;
  logic [7:0]  rd_latch;
  logic [7:0]  wr_latch;
  logic [2:0]  cs_cnt;
  logic        addr_hit;
  logic        rd_fall;
  logic        wr_fall;
  logic        lo_read;
  logic        hi_write;
  bwpb_term_ctl_t next_term;

  function automatic logic map_hit(input logic [15:0] a);
    map_hit = ((a & MAP_MASK) == (MAP_BASE & MAP_MASK));
  endfunction : map_hit

  assign cpu_raw = '{rd_n: cpu_rd_n_i, wr_n: cpu_wr_n_i, load_n: cpu_load_n_i,
                     regsel_n: cpu_regsel_n_i, addr: cpu_addr_i};

  bwpb_sync #(.WIDTH(CTL_W)) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (cpu_raw),
    .sync_o    (cpu_sync)
  );
  assign cpu = bwpb_cpu_ctl_t'(cpu_sync);

  // data buses also cross in; second stage feeds the latches
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_lo_s1 <= BYTE_RESET;
      data_lo_s2 <= BYTE_RESET;
      term_s1    <= {BYTE_RESET, BYTE_RESET};
      term_s2    <= {BYTE_RESET, BYTE_RESET};
    end else begin
      data_lo_s1 <= cpu_data_i;
      data_lo_s2 <= data_lo_s1;
      term_s1    <= term_data_i;
      term_s2    <= term_s1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_prev <= 1'b1;
      wr_prev <= 1'b1;
    end else begin
      rd_prev <= cpu.rd_n;
      wr_prev <= cpu.wr_n;
    end
  end

  assign rd_fall  = rd_prev & ~cpu.rd_n;
  assign wr_fall  = wr_prev & ~cpu.wr_n;
  assign addr_hit = map_hit(cpu.addr);
  assign lo_read  = ~cpu.rd_n & ~cpu.addr[0];
  assign hi_write = ~cpu.wr_n & ~cpu.load_n;

  // read latch: low byte of the word fetched by the strobe's falling edge; taken once
  // the terminal's answer to its output enable has crossed the data synchroniser
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_latch <= BYTE_RESET;
    end else if (~cpu.rd_n && addr_hit && cpu.addr[0] && (cs_cnt == RD_CAP_CNT)) begin
      rd_latch <= term_s2[7:0];
    end
  end

  // write latch: low byte registered each clock of a low-byte write while load_n is high
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_latch <= BYTE_RESET;
    end else if (~cpu.addr[0] && ~cpu.wr_n && cpu.load_n) begin
      wr_latch <= data_lo_s2;
    end
  end

  // chip select counter; a strobe shorter than the count is still covered
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cs_cnt <= 3'h0;
    end else if ((rd_fall || wr_fall) && addr_hit) begin
      cs_cnt <= CS_CNT_INIT;
    end else if (cs_cnt != 3'h0) begin
      cs_cnt <= cs_cnt - 3'h1;
    end
  end

  always_comb begin
    next_term.cs_n    = ~(((rd_fall || wr_fall) && addr_hit) || (cs_cnt > 3'h1));
    next_term.oe_n    = cpu.rd_n | ~addr_hit | lo_read;
    next_term.rd_wr_n = ~hi_write;
    next_term.ctrl_n  = cpu.regsel_n;
    next_term.dir_n   = ~cpu.wr_n ? 1'b0 : 1'b1;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      term_cs_n_o    <= 1'b1;
      term_oe_n_o    <= 1'b1;
      term_rd_wr_n_o <= 1'b1;
      term_ctrl_n_o  <= 1'b1;
      term_dir_n_o   <= 1'b1;
    end else begin
      term_cs_n_o    <= next_term.cs_n;
      term_oe_n_o    <= next_term.oe_n;
      term_rd_wr_n_o <= next_term.rd_wr_n;
      term_ctrl_n_o  <= next_term.ctrl_n;
      term_dir_n_o   <= next_term.dir_n;
    end
  end

  // data paths toward both buses
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cpu_data_o    <= BYTE_RESET;
      cpu_data_oe_o <= 1'b0;
      term_data_o   <= {BYTE_RESET, BYTE_RESET};
      term_lo_oe_o  <= 1'b0;
      term_hi_oe_o  <= 1'b0;
    end else begin
      cpu_data_o    <= lo_read ? rd_latch : term_s2[15:8];
      cpu_data_oe_o <= ~cpu.rd_n & (lo_read | addr_hit);
      term_data_o   <= {data_lo_s2, wr_latch};
      term_lo_oe_o  <= hi_write;
      term_hi_oe_o  <= ~cpu.wr_n & addr_hit & cpu.addr[0];
    end
  end

  chk_oe_lowread: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lo_read |=> term_oe_n_o) else $error("terminal enabled in low read");
  chk_oe_or: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (~cpu.rd_n & addr_hit & cpu.addr[0]) |=> !term_oe_n_o)
    else $error("output enable missing on read");
  chk_cs_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ((rd_fall || wr_fall) && addr_hit) |=> !term_cs_n_o [*4])
    else $error("chip select too short");
  chk_rdwr_combo: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cpu.load_n | cpu.wr_n) |=> term_rd_wr_n_o)
    else $error("write signalled outside high cycle");
  chk_load_drive: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    term_lo_oe_o |-> !$past(cpu.load_n)) else $error("latch driven without load");
  chk_dir_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ~cpu.wr_n |=> !term_dir_n_o) else $error("direction wrong on write");
  chk_lo_mux: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lo_read |=> (cpu_data_o == $past(rd_latch))) else $error("low byte not from latch");
  chk_ctrl_pass: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> (term_ctrl_n_o == $past(cpu.regsel_n))) else $error("select not passed");
endmodule : bwpb_bridge
`default_nettype wire

/* test/bwpb_term_model.sv */
// behavioural terminal word port: stores written words, returns the last one on reads
// assumes bridge outputs are registered on clk_i
`timescale 1ns/1ps
`default_nettype none
module bwpb_term_model (
  // clock
  input  wire logic        clk_i,
  // control from bridge
  input  wire logic        cs_n_i,
  input  wire logic        rd_wr_n_i,
  input  wire logic        oe_n_i,
  // data
  input  wire logic [15:0] data_i,
  output logic      [15:0] data_o
);
  logic [15:0] word = 16'h0000;
  // outputs off show the inverse, so a capture before the enable settles is caught
  assign data_o = oe_n_i ? ~word : word;
  always @(posedge clk_i) begin
    if (!cs_n_i && !rd_wr_n_i) begin
      word <= data_i;
    end
  end
endmodule : bwpb_term_model
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the byte-to-word bridge with a terminal model
// assumes 10 MHz clock and a pin-to-output lag of at most six cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bwpb_pkg::*;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        rd_n = 1'b1, wr_n = 1'b1, load_n = 1'b1, regsel_n = 1'b1;
  logic [15:0] addr = 16'h0000, tdata, tword;
  logic [7:0]  cdata = 8'h00, cpu_q;
  logic        cpu_oe, lo_oe, hi_oe, cs_n, oe_n, rw_n, ctrl_n, dir_n;
  int          mismatches = 0, cmp_count = 0, cs_cnt = 0;
  typedef struct { logic [15:0] w; logic rs; } bwpb_row_t;
  bwpb_row_t   rows [3] = '{'{16'hA55A, 1'b1}, '{16'h00FF, 1'b0}, '{16'hFF01, 1'b1}};

  bwpb_bridge bwpb_bridge_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cpu_rd_n_i(rd_n),
    .cpu_wr_n_i(wr_n), .cpu_load_n_i(load_n), .cpu_regsel_n_i(regsel_n), .cpu_addr_i(addr),
    .cpu_data_i(cdata), .cpu_data_o(cpu_q), .cpu_data_oe_o(cpu_oe), .term_data_i(tword),
    .term_data_o(tdata), .term_lo_oe_o(lo_oe), .term_hi_oe_o(hi_oe), .term_cs_n_o(cs_n),
    .term_oe_n_o(oe_n), .term_rd_wr_n_o(rw_n), .term_ctrl_n_o(ctrl_n), .term_dir_n_o(dir_n));
  bwpb_term_model bwpb_term_model_i (.clk_i(clk_i), .cs_n_i(cs_n), .rd_wr_n_i(rw_n),
    .oe_n_i(oe_n), .data_i(tdata), .data_o(tword));

  initial begin
    forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (!cs_n) begin
      cs_cnt++;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // start a strobe after a falling edge, let it settle past the pipeline lag
  task automatic go(input logic r, input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    cs_cnt = 0;
    rd_n = r; wr_n = w; addr = a; cdata = d;
    repeat (6) @(negedge clk_i);
  endtask : go
  task automatic rel();
    rd_n = 1'b1; wr_n = 1'b1;
    repeat (6) @(negedge clk_i);
  endtask : rel
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  initial begin
    #(3000 * CLK_PERIOD_NS);
    mismatches++;
    end_sim();
  end

  initial begin
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk({cs_n, cpu_oe, lo_oe, hi_oe, oe_n}, 16'h0011);
    $display("reset test done");
    foreach (rows[i]) begin
      regsel_n = rows[i].rs;
      go(1'b1, 1'b0, MAP_BASE_DEF, rows[i].w[7:0]);
      chk({rw_n, lo_oe}, 16'h0002);
      rel();
      load_n = 1'b0;
      go(1'b1, 1'b0, MAP_BASE_DEF | 16'h0001, rows[i].w[15:8]);
      chk(tdata, rows[i].w);
      chk({rw_n, dir_n, lo_oe, hi_oe, ctrl_n}, {14'h0003, rows[i].rs});
      rel();
      load_n = 1'b1;
      chk(16'(cs_cnt), 16'(CS_HOLD_CYCLES));
      go(1'b0, 1'b1, MAP_BASE_DEF | 16'h0001, 8'h00);
      chk({cpu_q, cpu_oe, oe_n, dir_n}, {rows[i].w[15:8], 3'h5});
      rel();
      chk(16'(cs_cnt), 16'(CS_HOLD_CYCLES));
      go(1'b0, 1'b1, MAP_BASE_DEF, 8'h00);
      chk({cpu_q, cpu_oe, oe_n, hi_oe}, {rows[i].w[7:0], 3'h6});
      rel();
      $display("row %0d done", i);
    end
    regsel_n = 1'b1;
    go(1'b0, 1'b1, 16'h0001, 8'h00);
    chk({cs_n, oe_n, cpu_oe, hi_oe}, 16'h000C);
    rel();
    chk(16'(cs_cnt), 16'h0000);
    $display("unmapped test done");
    go(1'b0, 1'b1, MAP_BASE_DEF | 16'h0001, 8'h00);
    sys_rst_i = 1'b1;
    @(negedge clk_i);
    chk({cs_n, cpu_oe, hi_oe}, 16'h0004);
    sys_rst_i = 1'b0;
    rel();
    $display("mid reset test done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
